// [hw/ctaf_pkg.sv]
// Package with register map, field layout and reset values for the block.
package ctaf_pkg;
    localparam int CTAF_NBUF = 3;
    localparam logic [3:0] ADDR_ABORT_ACK = 4'h0;
    localparam logic [3:0] ADDR_WIN_SEL = 4'h1;
    localparam logic [3:0] ADDR_FILT_CTRL = 4'h2;
    localparam logic [3:0] ADDR_TX_EMPTY = 4'h3;
    localparam logic [3:0] ADDR_ABORT_REQ = 4'h4;
    localparam logic [3:0] ADDR_INIT_CTRL = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
    localparam logic [2:0] BUF_FIELD_RST = 3'h0;
    localparam logic [2:0] TX_EMPTY_RST = 3'h7;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [2:0] HIT_RST = 3'h0;
    localparam int MODE_LSB = 4;
    localparam int MODE_MSB = 5;
    localparam int HIT_MSB = 2;
    localparam int INIT_RQ_BIT = 0;
    localparam int INIT_AK_BIT = 1;
    localparam int IRQ_W = 5;
    localparam int IRQ_TXE_LSB = 0;
    localparam int IRQ_ABORT_BIT = 3;
    localparam int IRQ_RX_BIT = 4;
    localparam logic [1:0] MODE_CLOSED = 2'h3;
    typedef enum logic [1:0] {
        CTAF_MODE_32, CTAF_MODE_16, CTAF_MODE_8, CTAF_MODE_SHUT
    } ctaf_mode_t;
endpackage

// [hw/ctaf_ctrl.sv]
// CAN transmit abort, buffer window select and acceptance control registers.
// Functional notes
// (RULE1) Abort acknowledge register stays at reset while init mode is active.
// (RULE2) Abort acknowledge flags are read-only; writes do nothing.
// (RULE3) Ack flag reads 1 if that buffer was aborted, else 0.
// (RULE4) Clearing a buffer's empty flag also clears its ack flag.
// (RULE5) Select register reset in init mode; writable only when out of it.
// (RULE6) Select register read shows only its lowest set bit.
// (RULE7) Lowest set select bit chooses the buffer shown in the window.
// (RULE8) Window access blocked while the selected buffer is scheduled.
// (RULE9) No buffer selected means no window access at all.
// (RULE10) Software claims a buffer by copying empty flags into select.
// (RULE11) Filter control writable only in init mode; hit bits read-only.
// (RULE12) Mode bits 5:4 pick 2x32, 4x16, 8x8 filters or closed.
// (RULE13) Closed filter accepts nothing; foreground buffer never reloads.
// (RULE14) Hit bits 2:0 hold the binary index of the matching filter.
// (RULE15) Hit bits update whenever a message enters the foreground buffer.
// (RULE16) Empty flag set on send or granted abort; clears abort request.
// (RULE17) Registers are 8 bits; unused bits read zero, ignore writes.
`timescale 1ns/1ps
module ctaf_ctrl
    import ctaf_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    output logic [7:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] tx_sent,
    input wire logic [2:0] tx_abort_granted,
    input wire logic init_mode_acknowledge,
    input wire logic rx_shift,
    input wire logic rx_filter_hit,
    input wire logic [2:0] rx_hit_index,
    input wire logic win_access,
    output logic rx_load,
    output logic [2:0] win_buffer_onehot,
    output logic win_allow,
    output logic [1:0] filter_organisation_mode,
    output logic init_mode_request,
    output logic [2:0] abort_request_bits,
    output logic [2:0] transmit_empty_flags,
    output logic irq
);
    logic init_rq_r;
    logic init_ak_r;
    logic init_ak_s_r;
    logic [2:0] abort_ack_flag_r;
    logic [2:0] sel_r;
    logic [2:0] txe_r;
    logic [2:0] abort_request_bit_r;
    logic [1:0] mode_r;
    logic [2:0] hit_r;
    logic [IRQ_W-1:0] stat_r;
    logic [IRQ_W-1:0] mask_r;
    logic rd_pend_r;
    logic [7:0] rdata_nxt;
    logic in_init;
    logic out_init;
    logic wr;
    logic [2:0] sel_low;
    logic [2:0] txe_set;
    logic [2:0] txe_clr;
    logic [IRQ_W-1:0] ev;

    // Isolates the lowest set bit of a three-bit field.
    function automatic logic [2:0] lowest_bit(input logic [2:0] v);
        return v & (~v + 3'h1);
    endfunction

    // Acknowledge comes from the protocol engine clock area, so sync it.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            init_ak_s_r <= 1'b0;
            init_ak_r <= 1'b0;
        end else begin
            init_ak_s_r <= init_mode_acknowledge;
            init_ak_r <= init_ak_s_r;
        end
    end

    assign in_init = init_rq_r && init_ak_r;
    assign out_init = !init_rq_r && !init_ak_r;
    // Writes complete in one cycle; reads add one wait cycle
    // so that read data comes from a flip-flop.
    assign wr = avs_write;
    assign avs_waitrequest = avs_read && !rd_pend_r;
    assign sel_low = lowest_bit(sel_r); // [RULE7]
    assign txe_set = (tx_sent | tx_abort_granted) & ~txe_r;
    assign txe_clr = (wr && avs_address == ADDR_TX_EMPTY) ?
        avs_writedata[2:0] : 3'h0;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= avs_read && !rd_pend_r;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            init_rq_r <= 1'b0;
        end else if (wr && avs_address == ADDR_INIT_CTRL) begin
            init_rq_r <= avs_writedata[INIT_RQ_BIT];
        end
    end

    // Transmit empty flags: software clears by writing one, engine sets.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            txe_r <= TX_EMPTY_RST;
        end else begin
            txe_r <= (txe_r & ~txe_clr) | txe_set; // [RULE16]
        end
    end

    // A set of the empty flag wins over a new request in the same cycle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            abort_request_bit_r <= BUF_FIELD_RST;
        end else if (in_init) begin
            abort_request_bit_r <= BUF_FIELD_RST;
        end else if (wr && avs_address == ADDR_ABORT_REQ && out_init) begin
            abort_request_bit_r <= (abort_request_bit_r | (avs_writedata[2:0] & ~txe_r)) & ~txe_set;
        end else begin
            abort_request_bit_r <= abort_request_bit_r & ~txe_set; // [RULE16]
        end
    end

    // Ack has no write path; a new grant wins over a same-cycle clear.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            abort_ack_flag_r <= BUF_FIELD_RST;
        end else if (in_init) begin
            abort_ack_flag_r <= BUF_FIELD_RST; // [RULE1]
        end else begin
            abort_ack_flag_r <= (abort_ack_flag_r & ~txe_clr) // [RULE4]
                | (tx_abort_granted & ~txe_r); // [RULE3] [RULE2]
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_r <= BUF_FIELD_RST;
        end else if (in_init) begin
            sel_r <= BUF_FIELD_RST; // [RULE5]
        end else if (wr && avs_address == ADDR_WIN_SEL && out_init) begin
            sel_r <= avs_writedata[2:0]; // [RULE5] [RULE10]
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_r <= MODE_RST;
        end else if (wr && avs_address == ADDR_FILT_CTRL && in_init) begin
            mode_r <= avs_writedata[MODE_MSB:MODE_LSB]; // [RULE11] [RULE12]
        end
    end

    // Hit index follows only messages that reach the foreground buffer.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hit_r <= HIT_RST;
        end else if (rx_load) begin
            hit_r <= rx_hit_index; // [RULE14] [RULE15]
        end
    end

    assign rx_load = rx_shift && rx_filter_hit
        && mode_r != MODE_CLOSED; // [RULE13]

    assign ev = {rx_load, |(tx_abort_granted & ~txe_r), txe_set};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stat_r <= '0;
        end else if (wr && avs_address == ADDR_IRQ_STAT) begin
            stat_r <= (stat_r & ~avs_writedata[IRQ_W-1:0]) | ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask_r <= '0;
        end else if (wr && avs_address == ADDR_IRQ_MASK) begin
            mask_r <= avs_writedata[IRQ_W-1:0];
        end
    end

    always_comb begin
        rdata_nxt = 8'h00; // [RULE17]
        unique case (avs_address)
            ADDR_ABORT_ACK: rdata_nxt[2:0] = abort_ack_flag_r;
            ADDR_WIN_SEL: rdata_nxt[2:0] = sel_low; // [RULE6]
            ADDR_FILT_CTRL: begin
                rdata_nxt[MODE_MSB:MODE_LSB] = mode_r;
                rdata_nxt[HIT_MSB:0] = hit_r;
            end
            ADDR_TX_EMPTY: rdata_nxt[2:0] = txe_r;
            ADDR_ABORT_REQ: rdata_nxt[2:0] = abort_request_bit_r;
            ADDR_INIT_CTRL: begin
                rdata_nxt[INIT_RQ_BIT] = init_rq_r;
                rdata_nxt[INIT_AK_BIT] = init_ak_r;
            end
            ADDR_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = stat_r;
            ADDR_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = mask_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 8'h00;
        end else if (avs_read && !rd_pend_r) begin
            avs_readdata <= rdata_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            win_buffer_onehot <= 3'h0;
            win_allow <= 1'b0;
        end else begin
            win_buffer_onehot <= sel_low;
            // A scheduled buffer is locked against the CPU.
            win_allow <= |(sel_low & txe_r); // [RULE8] [RULE9]
        end
    end

    assign filter_organisation_mode = mode_r;
    assign init_mode_request = init_rq_r;
    assign abort_request_bits = abort_request_bit_r;
    assign transmit_empty_flags = txe_r;
    assign irq = |(stat_r & mask_r);

    a_ack_init_clear: assert property (@(posedge clock) disable iff (!nrst)
        $past(in_init) |-> abort_ack_flag_r == 3'h0) // [RULE1]
        else $error("ack not held in init");
    a_ack_no_write: assert property (@(posedge clock) disable iff (!nrst)
        (tx_abort_granted == 3'h0 && !in_init) |=>
        (abort_ack_flag_r & ~$past(abort_ack_flag_r)) == 3'h0) // [RULE2]
        else $error("ack rose without grant");
    a_ack_on_grant: assert property (@(posedge clock) disable iff (!nrst)
        (!in_init && (tx_abort_granted & ~txe_r) != 3'h0) |=>
        (abort_ack_flag_r & $past(tx_abort_granted & ~txe_r))
        == $past(tx_abort_granted & ~txe_r)) // [RULE3]
        else $error("grant not acknowledged");
    a_ack_clr_txe: assert property (@(posedge clock) disable iff (!nrst)
        (txe_clr != 3'h0 && tx_abort_granted == 3'h0) |=>
        (abort_ack_flag_r & $past(txe_clr)) == 3'h0) // [RULE4]
        else $error("ack survived empty clear");
    a_sel_init: assert property (@(posedge clock) disable iff (!nrst)
        in_init |=> sel_r == 3'h0) // [RULE5]
        else $error("select not reset in init");
    a_sel_lowest: assert property (@(posedge clock) disable iff (!nrst)
        (avs_read && !rd_pend_r && avs_address == ADDR_WIN_SEL) |=>
        avs_readdata == {5'h00, $past(sel_low)} &&
        $countones(avs_readdata) <= 1) // [RULE6]
        else $error("select read not lowest bit");
    a_win_block: assert property (@(posedge clock) disable iff (!nrst)
        win_allow |-> $countones(win_buffer_onehot) == 1 &&
        (win_buffer_onehot & $past(txe_r)) != 3'h0) // [RULE8] [RULE9]
        else $error("window open to busy or none");
    a_filt_lock: assert property (@(posedge clock) disable iff (!nrst)
        (wr && avs_address == ADDR_FILT_CTRL && !in_init) |=>
        $stable(mode_r)) // [RULE11]
        else $error("filter control written outside init");
    a_closed_no_load: assert property (@(posedge clock) disable iff (!nrst)
        mode_r == MODE_CLOSED |-> !rx_load ##1 $stable(hit_r)) // [RULE13]
        else $error("closed filter loaded message");
    a_hit_update: assert property (@(posedge clock) disable iff (!nrst)
        rx_load |=> hit_r == $past(rx_hit_index)) // [RULE14] [RULE15]
        else $error("hit index not updated");
    a_txe_rq_clr: assert property (@(posedge clock) disable iff (!nrst)
        txe_set != 3'h0 |=> (abort_request_bit_r & $past(txe_set)) == 3'h0 &&
        (txe_r & $past(txe_set)) == $past(txe_set)) // [RULE16]
        else $error("empty set did not clear request");

    c_abort_seen: cover property (@(posedge clock) disable iff (!nrst)
        abort_ack_flag_r != 3'h0);
    c_win_open: cover property (@(posedge clock) disable iff (!nrst)
        win_allow);
    c_rx_load: cover property (@(posedge clock) disable iff (!nrst)
        rx_load);
    c_irq: cover property (@(posedge clock) disable iff (!nrst) irq);
endmodule

// [verif/ctaf_can_model.sv]
// Behavioural CAN protocol engine facing the register block.
`timescale 1ns/1ps
module ctaf_can_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic go,
    input wire logic init_mode_request,
    input wire logic [2:0] abort_request_bits,
    input wire logic [2:0] transmit_empty_flags,
    output logic init_mode_acknowledge,
    output logic [2:0] tx_sent,
    output logic [2:0] tx_abort_granted
);
    logic ack_dly_r;
    logic [2:0] busy;
    // A pulse masks its buffer because the empty flag answers a cycle late.
    assign busy = ~transmit_empty_flags & ~tx_sent & ~tx_abort_granted;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_dly_r <= 1'b0;
            init_mode_acknowledge <= 1'b0;
            tx_sent <= 3'h0;
            tx_abort_granted <= 3'h0;
        end else begin
            ack_dly_r <= init_mode_request;
            init_mode_acknowledge <= ack_dly_r;
            tx_abort_granted <= busy & abort_request_bits;
            // Holding go low stalls the bus so buffers stay scheduled.
            tx_sent <= go ? (busy & ~abort_request_bits) : 3'h0;
        end
    end
endmodule

// [verif/test_can_tx_abort_select_and_filter_ctrl.sv]
// Self-checking bench for the abort, window select and filter registers.
`timescale 1ns/1ps
module test_can_tx_abort_select_and_filter_ctrl import ctaf_pkg::*;;
    logic clock, nrst, avs_read, avs_write, rx_shift, rx_filter_hit, go;
    logic avs_waitrequest, init_ack, init_rq, rx_load, win_allow, irq;
    logic [3:0] avs_address;
    logic [7:0] avs_writedata, avs_readdata, rd_v, s;
    logic [2:0] tx_sent, tx_abort_granted, rx_hit_index, onehot;
    logic [2:0] abort_req, tx_empty, hit_exp;
    logic [1:0] mode, mx;
    int miscompares, compares, n;
    ctaf_ctrl i_dut (.clock(clock), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_sent(tx_sent),
        .tx_abort_granted(tx_abort_granted),
        .init_mode_acknowledge(init_ack), .rx_shift(rx_shift),
        .rx_filter_hit(rx_filter_hit), .rx_hit_index(rx_hit_index),
        .win_access(1'b0), .rx_load(rx_load), .win_buffer_onehot(onehot),
        .win_allow(win_allow), .filter_organisation_mode(mode),
        .init_mode_request(init_rq), .abort_request_bits(abort_req),
        .transmit_empty_flags(tx_empty), .irq(irq));
    ctaf_can_model i_eng (.clock(clock), .nrst(nrst), .go(go),
        .init_mode_request(init_rq), .abort_request_bits(abort_req),
        .transmit_empty_flags(tx_empty), .init_mode_acknowledge(init_ack),
        .tx_sent(tx_sent), .tx_abort_granted(tx_abort_granted));
    function automatic logic [2:0] lowbit(input logic [2:0] v);
        return v & (~v + 3'h1);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Waitrequest and read data are sampled mid-cycle, so the decision
    // belongs to the coming rising edge and never races its updates.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic w;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do begin
            @(negedge clock);
            w = avs_waitrequest;
            @(posedge clock);
        end while (w !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        logic w;
        avs_address <= a;
        avs_read <= 1'b1;
        do begin
            @(negedge clock);
            w = avs_waitrequest;
            d = avs_readdata;
            @(posedge clock);
        end while (w !== 1'b0);
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        rd(a, rd_v);
        chk(rd_v, exp);
    endtask
    task automatic set_init(input logic b);
        wr(ADDR_INIT_CTRL, {7'h0, b});
        do rd(ADDR_INIT_CTRL, rd_v); while (rd_v[INIT_AK_BIT] !== b);
    endtask
    task automatic wait_flags(input logic [2:0] exp);
        int k;
        k = 0;
        while (tx_empty !== exp && k < 50) begin
            @(posedge clock);
            k++;
        end
        chk({5'h0, tx_empty}, {5'h0, exp});
    endtask
    task automatic rx(input logic [2:0] idx);
        rx_shift <= 1'b1;
        rx_filter_hit <= 1'b1;
        rx_hit_index <= idx;
        #1 chk({7'h0, rx_load}, {7'h0, mx != MODE_CLOSED});
        @(posedge clock);
        rx_shift <= 1'b0;
        if (mx != MODE_CLOSED) hit_exp = idx;
        @(posedge clock);
        rchk(ADDR_FILT_CTRL, {2'h0, mx, 1'b0, hit_exp});
    endtask
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        results();
    end
    initial begin
        nrst = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 8'h00;
        rx_shift = 1'b0;
        rx_filter_hit = 1'b0;
        rx_hit_index = 3'h0;
        go = 1'b0;
        hit_exp = 3'h0;
        mx = 2'h0;
        s = 8'($urandom(41832));
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rchk(ADDR_ABORT_ACK, 8'h00);
        rchk(ADDR_FILT_CTRL, 8'h00);
        rchk(4'hF, 8'h00);
        // Schedule buffers 0 and 1 with the bus stalled, then abort both.
        wr(ADDR_TX_EMPTY, 8'h03);
        wr(ADDR_WIN_SEL, 8'h07);
        rchk(ADDR_WIN_SEL, 8'h01);
        chk({5'h0, onehot}, 8'h01);
        chk({7'h0, win_allow}, 8'h00);
        wr(ADDR_ABORT_REQ, 8'h03);
        wait_flags(3'h7);
        chk({5'h0, abort_req}, 8'h00);
        rchk(ADDR_ABORT_ACK, 8'h03);
        wr(ADDR_ABORT_ACK, 8'hFC);
        rchk(ADDR_ABORT_ACK, 8'h03);
        wr(ADDR_TX_EMPTY, 8'h01);
        rchk(ADDR_ABORT_ACK, 8'h02);
        set_init(1'b1);
        rchk(ADDR_ABORT_ACK, 8'h00);
        wr(ADDR_WIN_SEL, 8'h02);
        rchk(ADDR_WIN_SEL, 8'h00);
        for (n = 0; n < 4; n++) begin
            mx = n[1:0];
            s = 8'($urandom);
            wr(ADDR_FILT_CTRL, {s[7:6], mx, s[3:0]});
            rchk(ADDR_FILT_CTRL, {2'h0, mx, 1'b0, hit_exp});
            chk({6'h0, mode}, {6'h0, mx});
        end
        rx(3'h5);
        mx = 2'h0;
        wr(ADDR_FILT_CTRL, 8'h00);
        set_init(1'b0);
        wr(ADDR_FILT_CTRL, 8'h30);
        rchk(ADDR_FILT_CTRL, 8'h00);
        repeat (6) begin
            s = 8'($urandom);
            rx(s[2:0]);
        end
        // Buffer 0 is still scheduled; buffers 1 and 2 are empty.
        for (n = 0; n < 10; n++) begin
            s = (n < 8) ? 8'(n) : 8'($urandom);
            wr(ADDR_WIN_SEL, s);
            rchk(ADDR_WIN_SEL, {5'h0, lowbit(s[2:0])});
            chk({5'h0, onehot}, {5'h0, lowbit(s[2:0])});
            chk({7'h0, win_allow}, {7'h0, |(lowbit(s[2:0]) & 3'h6)});
        end
        rchk(ADDR_TX_EMPTY, 8'h06);
        wr(ADDR_WIN_SEL, 8'h06);
        rchk(ADDR_WIN_SEL, 8'h02);
        wr(ADDR_IRQ_STAT, 8'hFF);
        wr(ADDR_IRQ_MASK, 8'h01);
        chk({7'h0, irq}, 8'h00);
        go <= 1'b1;
        wait_flags(3'h7);
        rchk(ADDR_ABORT_ACK, 8'h00);
        rchk(ADDR_IRQ_STAT, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h1E);
        chk({7'h0, irq}, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h01);
        chk({7'h0, irq}, 8'h00);
        results();
    end
endmodule
